// ---- design/rirq_top.sv ----
/*
 * Interrupt line routing, queue flags, fill and transmit-start control,
 * signal level and lock flags, and filter settings of the radio.
 * Assumes radio events and queue status come from logic on the same clock;
 * only the raw lock indication comes from outside and is synchronised.
 */
// Strobed register access was decided locally.
`timescale 1ns/100ps
module rirq_top #(
	parameter int RAMP_23_CYC = rirq_pkg::RIRQ_RAMP_23_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Radio state and events
	input wire logic [1:0] data_mode_field,
	input wire rirq_pkg::rirq_op_t op_mode,
	input wire logic addr_filter_en,
	input wire rirq_pkg::rirq_events_t events,
	input wire rirq_pkg::rirq_queue_t queue,
	input wire logic [7:0] signal_level,
	input wire logic synth_lock_raw,
	// Interrupt lines and lock pin
	output logic int_line_a,
	output logic int_line_b,
	output logic lock_output_pin_o,
	output logic lock_output_pin_oe,
	// Radio control
	output logic tx_start,
	output logic queue_clear,
	output logic fill_enable,
	output logic [12:0] amp_ramp_cycles,
	output logic [9:0] passive_bw_khz,
	output logic [8:0] rx_bw_offset_khz
);
	import rirq_pkg::*;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [12:0] ramp_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: ramp_cycles = 13'(RIRQ_RAMP_3_CYC);
			2'h1: ramp_cycles = 13'(RIRQ_RAMP_8_5_CYC);
			2'h2: ramp_cycles = 13'(RIRQ_RAMP_15_CYC);
			default: ramp_cycles = 13'(RAMP_23_CYC);
		endcase
	endfunction : ramp_cycles

	function automatic logic wr_at(input logic [7:0] ofs);
		wr_at = reg_wr && (reg_addr == ofs);
	endfunction : wr_at

	// ****************************************
	// Registers and state
	// ****************************************
	logic [7:0] amp_reg;
	logic [1:0] line_a_rx_source_sel_reg;
	logic [1:0] line_b_rx_source_sel_reg;
	logic line_b_tx_source_sel_reg;
	logic queue_overrun_flag_reg;
	logic fill_method_sel_reg;
	logic transmit_complete_reg;
	logic tx_start_condition_sel_reg;
	logic signal_level_irq_enable_reg;
	logic signal_level_irq_flag_reg;
	logic synth_lock_status_reg;
	logic synth_lock_detect_enable_reg;
	logic [7:0] signal_level_threshold_reg;
	logic [7:0] filt_reg;
	logic [5:0] queue_level_setting_reg;
	rirq_fill_t fill_reg, fill_next;
	logic [2:0] lock_sync_reg;
	logic lock_level_reg;
	logic line_a_next, line_b_next, tx_start_next;
	logic [7:0] rdata_next;

	wire logic is_cont = (data_mode_field == 2'h0);
	wire logic is_buf = (data_mode_field == 2'h1);
	wire logic is_tx = (op_mode == RIRQ_OP_TX);
	wire logic queue_empty_flag = !queue.empty;
	wire logic queue_full_flag = queue.full;
	wire logic thr_hit = (queue.count >= {1'b0, queue_level_setting_reg});
	wire logic lvl_src = signal_level_irq_flag_reg;
	wire logic lvl_above = signal_level > signal_level_threshold_reg;
	wire logic ovr_clr = wr_at(RIRQ_OFS_IRQCFG) && reg_wdata[RIRQ_B_OVR];
	wire logic lvl_clr = wr_at(RIRQ_OFS_CTL) && reg_wdata[RIRQ_B_LVL_FLAG];
	wire logic lock_clr = wr_at(RIRQ_OFS_CTL) && reg_wdata[RIRQ_B_LOCK];

	// ****************************************
	// Configuration writes
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			amp_reg <= RIRQ_RST_AMP;
			line_a_rx_source_sel_reg <= RIRQ_RST_IRQCFG[7:6];
			line_b_rx_source_sel_reg <= RIRQ_RST_IRQCFG[5:4];
			line_b_tx_source_sel_reg <= RIRQ_RST_IRQCFG[3];
			fill_method_sel_reg <= RIRQ_RST_CTL[7];
			tx_start_condition_sel_reg <= RIRQ_RST_CTL[4];
			signal_level_irq_enable_reg <= RIRQ_RST_CTL[3];
			synth_lock_detect_enable_reg <= RIRQ_RST_CTL[0];
			signal_level_threshold_reg <= RIRQ_RST_THR;
			filt_reg <= RIRQ_RST_FILT;
			queue_level_setting_reg <= RIRQ_RST_QLVL;
		end else begin
			if (wr_at(RIRQ_OFS_AMP)) amp_reg <= reg_wdata;
			if (wr_at(RIRQ_OFS_IRQCFG)) begin
				line_a_rx_source_sel_reg <= reg_wdata[7:6];
				line_b_rx_source_sel_reg <= reg_wdata[5:4];
				line_b_tx_source_sel_reg <= reg_wdata[RIRQ_B_LINEB_TX];
			end
			if (wr_at(RIRQ_OFS_CTL)) begin
				fill_method_sel_reg <= reg_wdata[RIRQ_B_FILL_M];
				tx_start_condition_sel_reg <= reg_wdata[RIRQ_B_TXST];
				signal_level_irq_enable_reg <= reg_wdata[RIRQ_B_LVL_EN];
				synth_lock_detect_enable_reg <= reg_wdata[RIRQ_B_LOCK_EN];
			end
			if (wr_at(RIRQ_OFS_THR)) signal_level_threshold_reg <= reg_wdata;
			if (wr_at(RIRQ_OFS_FILT)) filt_reg <= reg_wdata;
			if (wr_at(RIRQ_OFS_QLVL)) queue_level_setting_reg <= reg_wdata[5:0];
		end
	end

	// ****************************************
	// Sticky flags
	// ****************************************
	// An event in the clearing cycle wins, so no overrun or level crossing is lost
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			queue_overrun_flag_reg <= 1'b0;
			queue_clear <= 1'b0;
			signal_level_irq_flag_reg <= 1'b0;
			synth_lock_status_reg <= 1'b0;
			transmit_complete_reg <= 1'b0;
		end else begin
			queue_overrun_flag_reg <= events.overrun || (queue_overrun_flag_reg && !ovr_clr);
			queue_clear <= ovr_clr;
			signal_level_irq_flag_reg <= signal_level_irq_enable_reg
				&& (lvl_above || (signal_level_irq_flag_reg && !lvl_clr));
			synth_lock_status_reg <= synth_lock_detect_enable_reg
				&& (lock_level_reg || (synth_lock_status_reg && !lock_clr));
			transmit_complete_reg <= events.last_bit_out
				|| (transmit_complete_reg && !(tx_start_next && !tx_start));
		end
	end

	// ****************************************
	// Lock input synchroniser
	// ****************************************
	// Third stage agreeing with the second filters single-cycle glitches
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lock_sync_reg <= 3'h0;
			lock_level_reg <= 1'b0;
		end else begin
			lock_sync_reg <= {lock_sync_reg[1:0], synth_lock_raw};
			if (lock_sync_reg[1] == lock_sync_reg[2]) begin
				lock_level_reg <= lock_sync_reg[2];
			end
		end
	end

	// ****************************************
	// Queue fill control
	// ****************************************
	always_comb begin
		fill_next = fill_reg;
		case (fill_reg)
			RIRQ_FILL_IDLE: begin
				if (is_buf && !fill_method_sel_reg && !is_tx && events.sync) begin
					fill_next = RIRQ_FILL_RUN;
				end else if (is_buf && fill_method_sel_reg && wr_at(RIRQ_OFS_CTL)
					&& reg_wdata[RIRQ_B_FILL]) begin
					fill_next = RIRQ_FILL_RUN;
				end
			end
			RIRQ_FILL_RUN: begin
				if (!is_buf || queue.full || events.overrun) begin
					fill_next = RIRQ_FILL_IDLE;
				end else if (fill_method_sel_reg && wr_at(RIRQ_OFS_CTL)
					&& !reg_wdata[RIRQ_B_FILL]) begin
					fill_next = RIRQ_FILL_IDLE;
				end
			end
			default: fill_next = RIRQ_FILL_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fill_reg <= RIRQ_FILL_IDLE;
			fill_enable <= 1'b0;
		end else begin
			fill_reg <= fill_next;
			fill_enable <= (fill_next == RIRQ_FILL_RUN);
		end
	end

	// ****************************************
	// Interrupt line routing and transmit start
	// ****************************************
	always_comb begin
		line_a_next = 1'b0;
		line_b_next = 1'b0;
		tx_start_next = 1'b0;
		if (!is_tx) begin
			if (is_cont) begin
				line_a_next = (line_a_rx_source_sel_reg == 2'h1) ? lvl_src : events.sync;
				line_b_next = events.recovered_bit_clock;
			end else begin
				case (line_a_rx_source_sel_reg)
					2'h3: line_a_next = (!is_buf && addr_filter_en) ?
						events.address_match_event : events.sync;
					2'h2: line_a_next = queue_empty_flag;
					2'h1: line_a_next = events.byte_written_event;
					default: line_a_next = !is_buf && events.payload_ready_event;
				endcase
				case (line_b_rx_source_sel_reg)
					2'h3: line_b_next = thr_hit;
					2'h2: line_b_next = lvl_src;
					2'h1: line_b_next = queue_full_flag;
					default: line_b_next = !is_buf && events.checksum_good_event;
				endcase
			end
		end else if (is_cont) begin
			line_b_next = events.recovered_bit_clock;
		end else begin
			line_b_next = line_b_tx_source_sel_reg ? transmit_complete_reg : queue_full_flag;
			if (is_buf || tx_start_condition_sel_reg) begin
				line_a_next = queue_empty_flag;
			end else begin
				line_a_next = thr_hit;
			end
			if (tx_start_condition_sel_reg) begin
				tx_start_next = !queue.empty;
			end else if (is_buf) begin
				tx_start_next = queue.full;
			end else begin
				tx_start_next = thr_hit;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			int_line_a <= 1'b0;
			int_line_b <= 1'b0;
			tx_start <= 1'b0;
			lock_output_pin_o <= 1'b0;
			lock_output_pin_oe <= 1'b0;
		end else begin
			int_line_a <= line_a_next;
			int_line_b <= line_b_next;
			tx_start <= tx_start_next;
			lock_output_pin_o <= synth_lock_status_reg;
			lock_output_pin_oe <= synth_lock_detect_enable_reg;
		end
	end

	// ****************************************
	// Analog settings
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			amp_ramp_cycles <= 13'h0;
			passive_bw_khz <= 10'h0;
			rx_bw_offset_khz <= 9'h0;
		end else begin
			amp_ramp_cycles <= ramp_cycles(amp_reg[4:3]);
			passive_bw_khz <= RIRQ_PASSIVE_KHZ[filt_reg[7:4]];
			// Offset holds for the nominal crystal; other crystals scale it linearly
			rx_bw_offset_khz <= 9'h19 * (9'(filt_reg[3:0]) + 9'h1);
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	always_comb begin
		case (reg_addr)
			RIRQ_OFS_QLVL: rdata_next = {2'h0, queue_level_setting_reg};
			RIRQ_OFS_AMP: rdata_next = amp_reg;
			RIRQ_OFS_IRQCFG: rdata_next = {line_a_rx_source_sel_reg, line_b_rx_source_sel_reg,
				line_b_tx_source_sel_reg, queue_full_flag, queue_empty_flag,
				queue_overrun_flag_reg};
			RIRQ_OFS_CTL: rdata_next = {fill_method_sel_reg, fill_reg == RIRQ_FILL_RUN,
				transmit_complete_reg, tx_start_condition_sel_reg, signal_level_irq_enable_reg,
				signal_level_irq_flag_reg, synth_lock_status_reg, synth_lock_detect_enable_reg};
			RIRQ_OFS_THR: rdata_next = signal_level_threshold_reg;
			RIRQ_OFS_FILT: rdata_next = filt_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_next : 8'h00;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	property p_ramp;
		(amp_reg[4:3] == 2'h1) |=> (amp_ramp_cycles == 13'(RIRQ_RAMP_8_5_CYC));
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp count wrong");
	property p_cont_a;
		(!is_tx && is_cont && line_a_rx_source_sel_reg == 2'h1) |=> (int_line_a == $past(lvl_src));
	endproperty
	a_cont_a: assert property (p_cont_a) else $error("line A not level");
	property p_buf_none;
		(!is_tx && is_buf && line_a_rx_source_sel_reg == 2'h0) |=> !int_line_a;
	endproperty
	a_buf_none: assert property (p_buf_none) else $error("line A active");
	property p_pkt_payload;
		(!is_tx && data_mode_field[1] && line_a_rx_source_sel_reg == 2'h0)
			|=> (int_line_a == $past(events.payload_ready_event));
	endproperty
	a_pkt_payload: assert property (p_pkt_payload) else $error("line A not payload");
	property p_cont_b;
		(is_cont) |=> (int_line_b == $past(events.recovered_bit_clock));
	endproperty
	a_cont_b: assert property (p_cont_b) else $error("line B not bit clock");
	property p_tx_b;
		(is_tx && !is_cont && !line_b_tx_source_sel_reg) |=> (int_line_b == $past(queue.full));
	endproperty
	a_tx_b: assert property (p_tx_b) else $error("line B not full");
	property p_ovr;
		(ovr_clr && !events.overrun) |=> (queue_clear && !queue_overrun_flag_reg)
			##1 (queue_clear == $past(ovr_clr));
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun clear wrong");
	property p_fill;
		(fill_reg == RIRQ_FILL_IDLE && is_buf && !fill_method_sel_reg && !is_tx && events.sync)
			|=> fill_enable;
	endproperty
	a_fill: assert property (p_fill) else $error("auto fill missed");
	property p_pkt_start;
		(is_tx && data_mode_field[1] && !tx_start_condition_sel_reg && thr_hit)
			|=> (tx_start && int_line_a);
	endproperty
	a_pkt_start: assert property (p_pkt_start) else $error("threshold start missed");
	property p_lvl_off;
		!signal_level_irq_enable_reg |=> !signal_level_irq_flag_reg;
	endproperty
	a_lvl_off: assert property (p_lvl_off) else $error("level flag while off");
	property p_lock_pin;
		!synth_lock_detect_enable_reg |=> !lock_output_pin_oe ##1 !lock_output_pin_o;
	endproperty
	a_lock_pin: assert property (p_lock_pin) else $error("lock pin driven");

	c_fill: cover property (fill_reg == RIRQ_FILL_IDLE ##1 fill_reg == RIRQ_FILL_RUN);
	c_txstart: cover property (is_tx && $rose(tx_start));
	c_ovr: cover property (queue_overrun_flag_reg ##1 queue_clear);

endmodule : rirq_top

// ---- design/rirq_pkg.sv ----
/*
 * Constants, types and register map of the radio interrupt routing and
 * configuration block. Assumes one 200 MHz clock and an 8-bit register port.
 */
package rirq_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] RIRQ_OFS_QLVL = 8'h05;
	localparam logic [7:0] RIRQ_OFS_AMP = 8'h0c;
	localparam logic [7:0] RIRQ_OFS_IRQCFG = 8'h0d;
	localparam logic [7:0] RIRQ_OFS_CTL = 8'h0e;
	localparam logic [7:0] RIRQ_OFS_THR = 8'h0f;
	localparam logic [7:0] RIRQ_OFS_FILT = 8'h10;

	localparam logic [7:0] RIRQ_RST_AMP = 8'h38;
	localparam logic [7:0] RIRQ_RST_IRQCFG = 8'h00;
	localparam logic [7:0] RIRQ_RST_CTL = 8'h01;
	localparam logic [7:0] RIRQ_RST_THR = 8'h00;
	localparam logic [7:0] RIRQ_RST_FILT = 8'ha3;
	localparam logic [5:0] RIRQ_RST_QLVL = 6'h0f;

	// Passive filter bandwidth in kHz, indexed by its code
	localparam logic [9:0] RIRQ_PASSIVE_KHZ [16] = '{10'h41, 10'h52, 10'h6d, 10'h89, 10'h9d,
		10'hb8, 10'hd3, 10'hea, 10'h106, 10'h141, 10'h17a, 10'h19e, 10'h1ca, 10'h202,
		10'h2a4, 10'h3db};

	// Bit positions
	localparam int RIRQ_B_OVR = 0;
	localparam int RIRQ_B_NEMPTY = 1;
	localparam int RIRQ_B_FULL = 2;
	localparam int RIRQ_B_LINEB_TX = 3;
	localparam int RIRQ_B_LOCK_EN = 0;
	localparam int RIRQ_B_LOCK = 1;
	localparam int RIRQ_B_LVL_FLAG = 2;
	localparam int RIRQ_B_LVL_EN = 3;
	localparam int RIRQ_B_TXST = 4;
	localparam int RIRQ_B_TXC = 5;
	localparam int RIRQ_B_FILL = 6;
	localparam int RIRQ_B_FILL_M = 7;

	// ****************************************
	// Timing
	// ****************************************
	localparam int RIRQ_CLK_NS = 5;
	localparam int RIRQ_RAMP_3_NS = 3000;
	localparam int RIRQ_RAMP_8_5_NS = 8500;
	localparam int RIRQ_RAMP_15_NS = 15000;
	localparam int RIRQ_RAMP_23_NS = 23000;
	localparam int RIRQ_RAMP_3_CYC = (RIRQ_RAMP_3_NS + RIRQ_CLK_NS - 1) / RIRQ_CLK_NS;
	localparam int RIRQ_RAMP_8_5_CYC = (RIRQ_RAMP_8_5_NS + RIRQ_CLK_NS - 1) / RIRQ_CLK_NS;
	localparam int RIRQ_RAMP_15_CYC = (RIRQ_RAMP_15_NS + RIRQ_CLK_NS - 1) / RIRQ_CLK_NS;
	localparam int RIRQ_RAMP_23_CYC = (RIRQ_RAMP_23_NS + RIRQ_CLK_NS - 1) / RIRQ_CLK_NS;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		RIRQ_OP_STBY = 3'h1,
		RIRQ_OP_RX = 3'h2,
		RIRQ_OP_TX = 3'h4
	} rirq_op_t;

	typedef enum logic [1:0] {
		RIRQ_FILL_IDLE = 2'h1,
		RIRQ_FILL_RUN = 2'h2
	} rirq_fill_t;

	typedef struct packed {
		logic sync;
		logic byte_written_event;
		logic payload_ready_event;
		logic address_match_event;
		logic checksum_good_event;
		logic recovered_bit_clock;
		logic overrun;
		logic last_bit_out;
	} rirq_events_t;

	typedef struct packed {
		logic full;
		logic empty;
		logic [6:0] count;
	} rirq_queue_t;

endpackage : rirq_pkg

// ---- testbench/rirq_host.sv ----
/*
 * Host model: register port master with one-cycle strobes.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/100ps
module rirq_host (
	// Clock
	input wire logic clock,
	// Register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	import rirq_pkg::*;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		// Idle data must not look like the last write
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic set_ramp(input logic [1:0] f);
		wr(RIRQ_OFS_AMP, {3'b001, f, 3'b000});
	endtask : set_ramp
	task automatic fill_ctl(input logic on);
		// Manual method must already be selected when the start or stop bit is written
		wr(RIRQ_OFS_CTL, {1'b1, 1'b0, 6'h01});
		wr(RIRQ_OFS_CTL, {1'b1, on, 6'h01});
	endtask : fill_ctl
endmodule : rirq_host

// ---- testbench/tb_rirq_top.sv ----
/*
 * Self-checking bench: the host model drives registers, the bench drives
 * radio events and compares outputs with its own model.
 * Assumes one 200 MHz clock; the long ramp count is shortened.
 */
`timescale 1ns/100ps
module tb_rirq_top;
	import rirq_pkg::*;
	localparam int RAMP = 20;
	localparam int QLVL = 15;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, t;
	logic reg_wr, reg_rd, ts, tsel;
	logic [1:0] data_mode_field = 2'h0;
	rirq_op_t op_mode = RIRQ_OP_STBY;
	logic addr_filter_en = 1'b0;
	rirq_events_t events = '0;
	rirq_queue_t queue = 9'h080;
	logic [7:0] signal_level = 8'h00;
	logic synth_lock_raw = 1'b0;
	logic int_line_a, int_line_b, lock_o, lock_oe, tx_start, queue_clear, fill_enable;
	logic [12:0] amp_ramp_cycles;
	logic [9:0] passive_bw_khz;
	logic [8:0] rx_bw_offset_khz;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	int bw [16] = '{65, 82, 109, 137, 157, 184, 211, 234, 262, 321, 378, 414, 458, 514, 676, 987};
	int ramp [4] = '{600, 1700, 3000, RAMP};
	logic [7:0] ra [7] = '{8'h05, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h20};
	logic [7:0] rv [7] = '{8'h0f, 8'h38, 8'h00, 8'h01, 8'h00, 8'ha3, 8'h00};

	rirq_top #(.RAMP_23_CYC(RAMP)) u_rirq_top (.clock(clock), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .data_mode_field(data_mode_field), .op_mode(op_mode),
		.addr_filter_en(addr_filter_en), .events(events), .queue(queue),
		.signal_level(signal_level), .synth_lock_raw(synth_lock_raw),
		.int_line_a(int_line_a), .int_line_b(int_line_b), .lock_output_pin_o(lock_o),
		.lock_output_pin_oe(lock_oe), .tx_start(tx_start), .queue_clear(queue_clear),
		.fill_enable(fill_enable), .amp_ramp_cycles(amp_ramp_cycles),
		.passive_bw_khz(passive_bw_khz), .rx_bw_offset_khz(rx_bw_offset_khz));
	rirq_host u_rirq_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			results();
		end
	end

	// ****************************************
	// Reference model
	// ****************************************
	task automatic results;
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle
	function automatic rirq_op_t to_op(int o);
		return o == 0 ? RIRQ_OP_STBY : o == 1 ? RIRQ_OP_RX : RIRQ_OP_TX;
	endfunction : to_op
	// Level source stays 0 here: its enable is off during the sweep
	function automatic logic exp_a(int m, int s, int o, logic ts, logic af);
		if (o == 2)
			return m == 0 ? 1'b0 : (m == 1 || ts) ? !queue.empty : queue.count >= QLVL;
		case (s)
			3: return (m > 1 && af) ? events.address_match_event : events.sync;
			2: return m == 0 ? events.sync : !queue.empty;
			1: return m == 0 ? 1'b0 : events.byte_written_event;
			default: return m == 0 ? events.sync : m == 1 ? 1'b0 : events.payload_ready_event;
		endcase
	endfunction : exp_a
	function automatic logic exp_b(int m, int s, int o, logic tsel);
		if (m == 0)
			return events.recovered_bit_clock;
		if (o == 2)
			return tsel ? 1'b0 : queue.full;
		case (s)
			3: return queue.count >= QLVL;
			2: return 1'b0;
			1: return queue.full;
			default: return m == 1 ? 1'b0 : events.checksum_good_event;
		endcase
	endfunction : exp_b
	function automatic logic exp_tx(int m, int o, logic ts);
		if (o != 2)
			return 1'b0;
		if (ts)
			return !queue.empty;
		return m == 1 ? queue.full : queue.count >= QLVL;
	endfunction : exp_tx

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		void'($urandom(30));
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		settle(1);
		chk(amp_ramp_cycles, RAMP);
		chk(passive_bw_khz, 378);
		chk(rx_bw_offset_khz, 100);
		chk(lock_oe, 1'b1);
		u_rirq_host.wr(8'h20, 8'hff);
		foreach (ra[i]) begin
			u_rirq_host.rd(ra[i], rd);
			chk(rd, rv[i]);
		end
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 16; s++)
				for (int o = 0; o < 3; o++) begin
					ts = 1'($urandom);
					tsel = 1'($urandom);
					u_rirq_host.wr(RIRQ_OFS_CTL, {3'h0, ts, 4'h1});
					u_rirq_host.wr(RIRQ_OFS_IRQCFG, {s[3:0], tsel, 3'h0});
					data_mode_field <= 2'(m);
					op_mode <= to_op(o);
					addr_filter_en <= 1'($urandom);
					events <= rirq_events_t'(8'($urandom) & 8'hfc);
					queue <= rirq_queue_t'(9'($urandom));
					settle(3);
					chk(int_line_a, exp_a(m, s / 4, o, ts, addr_filter_en));
					chk(int_line_b, exp_b(m, s % 4, o, tsel));
					if (m != 0)
						chk(tx_start, exp_tx(m, o, ts));
					u_rirq_host.rd(RIRQ_OFS_IRQCFG, rd);
					chk(rd[2:1], {queue.full, !queue.empty});
				end
		events <= '0;
		queue <= 9'h001;
		op_mode <= RIRQ_OP_RX;
		data_mode_field <= 2'h0;
		t = 8'($urandom % 255);
		u_rirq_host.wr(RIRQ_OFS_THR, t);
		u_rirq_host.rd(RIRQ_OFS_THR, rd);
		chk(rd, t);
		u_rirq_host.wr(RIRQ_OFS_IRQCFG, 8'h40);
		signal_level <= t + 8'h01;
		settle(3);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[2], 1'b0);
		u_rirq_host.wr(RIRQ_OFS_CTL, 8'h09);
		settle(3);
		chk(int_line_a, 1'b1);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[3:2], 2'b11);
		signal_level <= t;
		u_rirq_host.wr(RIRQ_OFS_CTL, 8'h0d);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[2], 1'b0);
		events <= 8'h02;
		settle(1);
		events <= '0;
		u_rirq_host.rd(RIRQ_OFS_IRQCFG, rd);
		chk(rd[0], 1'b1);
		u_rirq_host.wr(RIRQ_OFS_IRQCFG, 8'h01);
		#1 chk(queue_clear, 1'b1);
		settle(1);
		chk(queue_clear, 1'b0);
		u_rirq_host.rd(RIRQ_OFS_IRQCFG, rd);
		chk(rd[0], 1'b0);
		synth_lock_raw <= 1'b1;
		settle(8);
		chk({lock_o, lock_oe}, 2'b11);
		synth_lock_raw <= 1'b0;
		settle(6);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[1:0], 2'b11);
		u_rirq_host.wr(RIRQ_OFS_CTL, 8'h03);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[1], 1'b0);
		u_rirq_host.wr(RIRQ_OFS_CTL, 8'h00);
		settle(2);
		chk({lock_o, lock_oe}, 2'b00);
		data_mode_field <= 2'h1;
		u_rirq_host.wr(RIRQ_OFS_CTL, 8'h01);
		events <= 8'h80;
		settle(1);
		events <= '0;
		settle(2);
		chk(fill_enable, 1'b1);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[6], 1'b1);
		queue <= 9'h101;
		settle(3);
		chk(fill_enable, 1'b0);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[6], 1'b0);
		queue <= 9'h001;
		u_rirq_host.fill_ctl(1'b1);
		settle(2);
		chk(fill_enable, 1'b1);
		u_rirq_host.fill_ctl(1'b0);
		settle(2);
		chk(fill_enable, 1'b0);
		data_mode_field <= 2'h2;
		u_rirq_host.fill_ctl(1'b1);
		settle(2);
		chk(fill_enable, 1'b0);
		data_mode_field <= 2'h1;
		op_mode <= RIRQ_OP_TX;
		u_rirq_host.wr(RIRQ_OFS_IRQCFG, 8'h08);
		settle(2);
		chk(int_line_b, 1'b0);
		events <= 8'h01;
		settle(1);
		events <= '0;
		settle(2);
		chk(int_line_b, 1'b1);
		u_rirq_host.rd(RIRQ_OFS_CTL, rd);
		chk(rd[5], 1'b1);
		op_mode <= RIRQ_OP_RX;
		t = 8'($urandom % 63) + 8'h01;
		u_rirq_host.wr(RIRQ_OFS_QLVL, t);
		u_rirq_host.rd(RIRQ_OFS_QLVL, rd);
		chk(rd, {2'b00, t[5:0]});
		u_rirq_host.wr(RIRQ_OFS_IRQCFG, 8'h30);
		queue <= {3'b000, t[5:0]};
		settle(3);
		chk(int_line_b, 1'b1);
		queue <= {3'b000, t[5:0] - 6'h01};
		settle(3);
		chk(int_line_b, 1'b0);
		for (int c = 0; c < 16; c++) begin
			t = 8'($urandom % 16);
			u_rirq_host.wr(RIRQ_OFS_FILT, {c[3:0], t[3:0]});
			settle(2);
			chk(passive_bw_khz, bw[c]);
			chk(rx_bw_offset_khz, 25 * (1 + t));
		end
		for (int f = 0; f < 4; f++) begin
			u_rirq_host.set_ramp(f[1:0]);
			settle(2);
			chk(amp_ramp_cycles, ramp[f]);
			u_rirq_host.rd(RIRQ_OFS_AMP, rd);
			chk(rd, {3'b001, f[1:0], 3'b000});
		end
		results();
	end
endmodule : tb_rirq_top
